// File: design/sbp_defines.vh
// Constants for the slip buffer and pointer justifier: frame geometry,
// pointer word layout, fill thresholds and reset values.
// Assumes an include by bare name from every design file that needs it.
//
// Overview of operation
// - Bytes enter on upstream clock edges, leave on local read clock edges.
// - With fill inside the band, no adjustment; envelope offset stays fixed.
// - Fill below low threshold inserts one information-free dummy byte.
// - Dummy byte sits right after H3, moving J1 one byte later.
// - Positive stuff frame sends pointer word with I bits inverted.
// - Next frame restores I bits and carries pointer plus one.
// - Fill above high threshold removes one byte by negative stuffing.
// - The negatively stuffed byte is payload and is still delivered.
// - Negative stuff puts the extra payload byte into the H3 slot.
// - Negative stuff frame sends pointer word with D bits inverted.
// - Next frame restores D bits and carries pointer minus one.
// - Pointer is low ten bits of H1/H2; never above 0x30E.
// - Pointer zero puts J1 in the slot right after H3.
`ifndef SBP_DEFINES_VH
`define SBP_DEFINES_VH

// Frame geometry
`define SBP_ROWS         4'h9
`define SBP_COLS         7'h5a
`define SBP_TOH_COLS     7'h03
`define SBP_PTR_ROW      4'h3
`define SBP_H1_COL       7'h00
`define SBP_H2_COL       7'h01
`define SBP_H3_COL       7'h02
`define SBP_AFTER_H3_COL 7'h03

// Pointer word layout
`define SBP_NDF_NORMAL   4'h6
`define SBP_SS_BITS      2'h0
`define SBP_I_MASK       10'h2aa
`define SBP_D_MASK       10'h155
`define SBP_PTR_MAX      10'h30e
`define SBP_PTR_RESET    10'h000

// Buffer fill thresholds
`define SBP_FILL_LOW     5'h04
`define SBP_FILL_HIGH    5'h0c

// Byte values
`define SBP_FILL_BYTE    8'h00

`endif

// File: design/sbp_fifo.v
// Single-clock FIFO with show-ahead read and valid/ready on both sides.
// Assumes both sides run on clk; fill level is exported for the justifier.
`timescale 1ns/1ps
module sbp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire             clk,
    input  wire             sys_rst,
    // Fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    // Status
    output wire [AW:0]      fill_count
);

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_ff;
    reg [AW-1:0]    rd_ptr_ff;
    reg [AW:0]      count_ff;
    wire            push;
    wire            pop;

    localparam [AW:0] FULL_COUNT = DEPTH[AW:0];

    // Full and empty come straight from the count, no lookahead
    assign in_ready   = (count_ff != FULL_COUNT);
    assign out_valid  = (count_ff != {(AW+1){1'b0}});
    assign out_data   = mem[rd_ptr_ff];
    assign fill_count = count_ff;
    assign push       = in_valid & in_ready;
    assign pop        = out_valid & out_ready;

    // Storage has no reset; only pointers and count define validity
    always @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers and count
    always @(posedge clk) begin
        if (sys_rst) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push & ~pop) begin
                count_ff <= count_ff + {{AW{1'b0}}, 1'b1};
            end else if (pop & ~push) begin
                count_ff <= count_ff - {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule

// File: design/sbp_slip_buffer.v
// Slip buffer between an upstream byte stream and a locally timed STS-1
// frame generator that justifies the pointer by positive and negative stuffing.
// Assumes both link clocks are far slower than clk (at least 6 clk per period)
// and upstream data is stable around the rising edge of its clock.
`timescale 1ns/1ps
`include "sbp_defines.vh"
module sbp_slip_buffer (
    // System
    input  wire       clk,
    input  wire       sys_rst,
    // Upstream write side
    input  wire       upstream_write_clock,
    input  wire       buffer_write_enable,
    input  wire [7:0] buffer_write_data,
    output reg        write_ready_ff,
    output reg        write_overflow_ff,
    // Local read side
    input  wire       local_read_clock,
    output reg  [7:0] buffer_read_data_ff,
    output reg        read_strobe_ff,
    output reg        read_frame_start_ff,
    output reg        read_payload_ff,
    output reg        read_j1_ff,
    output reg        read_pos_stuff_ff,
    output reg        read_neg_stuff_ff,
    output reg  [9:0] pointer_value_ff,
    output reg        read_underrun_ff
);

    // ****************************************************************
    // Adjustment states
    // ****************************************************************
    localparam [2:0] ADJ_NONE = 3'b001;
    localparam [2:0] ADJ_INC  = 3'b010;
    localparam [2:0] ADJ_DEC  = 3'b100;

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    reg        wclk_s1_ff;
    reg        wclk_s2_ff;
    reg        wclk_s3_ff;
    reg        wen_s1_ff;
    reg        wen_s2_ff;
    reg  [7:0] wdat_s1_ff;
    reg  [7:0] wdat_s2_ff;
    reg        rclk_s1_ff;
    reg        rclk_s2_ff;
    reg        rclk_s3_ff;
    wire       wr_edge;
    wire       rd_edge;

    // Data rides the same two-stage path as its clock to stay aligned
    always @(posedge clk) begin
        if (sys_rst) begin
            wclk_s1_ff <= 1'b0;
            wclk_s2_ff <= 1'b0;
            wclk_s3_ff <= 1'b0;
            wen_s1_ff  <= 1'b0;
            wen_s2_ff  <= 1'b0;
            wdat_s1_ff <= 8'h00;
            wdat_s2_ff <= 8'h00;
            rclk_s1_ff <= 1'b0;
            rclk_s2_ff <= 1'b0;
            rclk_s3_ff <= 1'b0;
        end else begin
            wclk_s1_ff <= upstream_write_clock;
            wclk_s2_ff <= wclk_s1_ff;
            wclk_s3_ff <= wclk_s2_ff;
            wen_s1_ff  <= buffer_write_enable;
            wen_s2_ff  <= wen_s1_ff;
            wdat_s1_ff <= buffer_write_data;
            wdat_s2_ff <= wdat_s1_ff;
            rclk_s1_ff <= local_read_clock;
            rclk_s2_ff <= rclk_s1_ff;
            rclk_s3_ff <= rclk_s2_ff;
        end
    end

    // Rising edges, seen only after the second stage
    assign wr_edge = wclk_s2_ff & ~wclk_s3_ff;
    assign rd_edge = rclk_s2_ff & ~rclk_s3_ff;

    // ****************************************************************
    // Slip FIFO
    // ****************************************************************
    wire       fifo_in_valid;
    wire       fifo_in_ready;
    wire       fifo_out_valid;
    wire [7:0] fifo_out_data;
    wire [4:0] fifo_fill;
    reg        pop;

    assign fifo_in_valid = wr_edge & wen_s2_ff;

    sbp_fifo #(
        .WIDTH (8),
        .DEPTH (16),
        .AW    (4)
    ) u_fifo (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .in_valid   (fifo_in_valid),
        .in_ready   (fifo_in_ready),
        .in_data    (wdat_s2_ff),
        .out_valid  (fifo_out_valid),
        .out_ready  (pop),
        .out_data   (fifo_out_data),
        .fill_count (fifo_fill)
    );

    // Back-pressure seen by upstream; a byte offered while full is lost
    always @(posedge clk) begin
        if (sys_rst) begin
            write_ready_ff    <= 1'b0;
            write_overflow_ff <= 1'b0;
        end else begin
            write_ready_ff    <= fifo_in_ready;
            write_overflow_ff <= fifo_in_valid & ~fifo_in_ready;
        end
    end

    // ****************************************************************
    // Frame position and justification state
    // ****************************************************************
    reg  [3:0] row_ff;
    reg  [6:0] col_ff;
    reg  [2:0] adj_ff;
    reg  [9:0] ptr_ff;
    reg  [9:0] spe_cnt_ff;
    reg        started_ff;
    reg  [2:0] nxt_adj;
    reg  [9:0] nxt_ptr;
    reg  [9:0] tx_ptr;
    wire       frame_start;
    wire       ptr_row;
    wire       env_slot;
    wire [15:0] ptr_word;

    assign frame_start = (row_ff == 4'h0) && (col_ff == 7'h00);
    assign ptr_row     = (row_ff == `SBP_PTR_ROW);
    assign env_slot    = (col_ff >= `SBP_TOH_COLS);

    // Frame start decides this frame's type and applies last frame's change.
    // An adjustment frame is never followed directly by another one.
    always @* begin
        nxt_adj = adj_ff;
        nxt_ptr = ptr_ff;
        if (frame_start) begin
            nxt_adj = ADJ_NONE;
            case (adj_ff)
                ADJ_INC: begin
                    nxt_ptr = (ptr_ff == `SBP_PTR_MAX) ? 10'h000 : ptr_ff + 10'h001;
                end
                ADJ_DEC: begin
                    nxt_ptr = (ptr_ff == 10'h000) ? `SBP_PTR_MAX : ptr_ff - 10'h001;
                end
                default: begin
                    if (started_ff && (fifo_fill < `SBP_FILL_LOW)) begin
                        nxt_adj = ADJ_INC;
                    end else if (started_ff && (fifo_fill > `SBP_FILL_HIGH)) begin
                        nxt_adj = ADJ_DEC;
                    end
                end
            endcase
        end
    end

    // Pointer field with I or D bits inverted during an adjustment frame
    always @* begin
        tx_ptr = ptr_ff;
        case (adj_ff)
            ADJ_INC: tx_ptr = ptr_ff ^ `SBP_I_MASK;
            ADJ_DEC: tx_ptr = ptr_ff ^ `SBP_D_MASK;
            default: tx_ptr = ptr_ff;
        endcase
    end

    assign ptr_word = {`SBP_NDF_NORMAL, `SBP_SS_BITS, tx_ptr};

    // Which slot takes a payload byte from the buffer
    always @* begin
        pop = 1'b0;
        if (rd_edge && fifo_out_valid) begin
            if (env_slot) begin
                // Dummy byte right after H3 in an increment frame
                pop = started_ff | (ptr_row && (col_ff == `SBP_AFTER_H3_COL));
                if (started_ff && ptr_row && (col_ff == `SBP_AFTER_H3_COL) && (adj_ff == ADJ_INC)) begin
                    pop = 1'b0;
                end
            end else if (ptr_row && (col_ff == `SBP_H3_COL) && (adj_ff == ADJ_DEC)) begin
                pop = 1'b1;
            end
        end
    end

    // Frame counters and justification registers
    always @(posedge clk) begin
        if (sys_rst) begin
            row_ff      <= 4'h0;
            col_ff      <= 7'h00;
            adj_ff      <= ADJ_NONE;
            ptr_ff      <= `SBP_PTR_RESET;
            spe_cnt_ff  <= 10'h000;
            started_ff  <= 1'b0;
        end else if (rd_edge) begin
            adj_ff <= nxt_adj;
            ptr_ff <= nxt_ptr;
            if (col_ff == `SBP_COLS - 7'h01) begin
                col_ff <= 7'h00;
                row_ff <= (row_ff == `SBP_ROWS - 4'h1) ? 4'h0 : row_ff + 4'h1;
            end else begin
                col_ff <= col_ff + 7'h01;
            end
            // Envelope alignment begins at pointer zero, slot after H3
            if (pop) begin
                started_ff <= 1'b1;
                spe_cnt_ff <= (spe_cnt_ff == `SBP_PTR_MAX) ? 10'h000 : spe_cnt_ff + 10'h001;
            end
        end
    end

    // ****************************************************************
    // Output byte assembly
    // ****************************************************************
    always @(posedge clk) begin
        if (sys_rst) begin
            buffer_read_data_ff <= `SBP_FILL_BYTE;
            read_strobe_ff      <= 1'b0;
            read_frame_start_ff <= 1'b0;
            read_payload_ff     <= 1'b0;
            read_j1_ff          <= 1'b0;
            read_pos_stuff_ff   <= 1'b0;
            read_neg_stuff_ff   <= 1'b0;
            pointer_value_ff    <= `SBP_PTR_RESET;
            read_underrun_ff    <= 1'b0;
        end else begin
            read_strobe_ff      <= rd_edge;
            read_frame_start_ff <= rd_edge & frame_start;
            read_payload_ff     <= pop;
            read_j1_ff          <= pop & (spe_cnt_ff == 10'h000);
            // An empty buffer at a payload slot is an underrun, not a stuff
            read_underrun_ff    <= rd_edge & started_ff & ~fifo_out_valid &
                                   (env_slot | (ptr_row && (col_ff == `SBP_H3_COL) && (adj_ff == ADJ_DEC)));
            if (rd_edge && frame_start) begin
                read_pos_stuff_ff <= (nxt_adj == ADJ_INC);
                read_neg_stuff_ff <= (nxt_adj == ADJ_DEC);
                pointer_value_ff  <= nxt_ptr;
            end
            if (rd_edge) begin
                if (pop) begin
                    buffer_read_data_ff <= fifo_out_data;
                end else if (ptr_row && (col_ff == `SBP_H1_COL)) begin
                    buffer_read_data_ff <= ptr_word[15:8];
                end else if (ptr_row && (col_ff == `SBP_H2_COL)) begin
                    buffer_read_data_ff <= ptr_word[7:0];
                end else begin
                    buffer_read_data_ff <= `SBP_FILL_BYTE;
                end
            end
        end
    end

endmodule

// File: dv/sbp_checker.sv
// Checker: pointer word, stuffing slots and frame-to-frame pointer moves.
// Assumes a bind onto sbp_slip_buffer; sees its ports only.
`timescale 1ns/1ps
`include "sbp_defines.vh"
module sbp_checker (
    // System
    input wire       clk,
    input wire       sys_rst,
    // Read side
    input wire       read_strobe_ff,
    input wire       read_frame_start_ff,
    input wire       read_payload_ff,
    input wire       read_pos_stuff_ff,
    input wire       read_neg_stuff_ff,
    input wire [9:0] pointer_value_ff,
    input wire [7:0] buffer_read_data_ff
);
    // ****************
    // Slot tracking
    // ****************
    reg  [9:0] slot_ff;
    wire [9:0] cur_slot = read_frame_start_ff ? 10'h000 : slot_ff;
    wire [9:0] adj_mask = read_pos_stuff_ff ? `SBP_I_MASK : (read_neg_stuff_ff ? `SBP_D_MASK : 10'h000);
    wire [9:0] exp_word = pointer_value_ff ^ adj_mask;
    wire       adj_now  = read_pos_stuff_ff | read_neg_stuff_ff;

    // Slot of the byte on the wire; frame start restarts it
    always @(posedge clk) begin
        if (sys_rst) begin
            slot_ff <= 10'h000;
        end else if (read_strobe_ff) begin
            slot_ff <= cur_slot + 10'h001;
        end
    end

    // ****************
    // Assertions
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence frame_s; read_frame_start_ff; endsequence
    sequence h1_s; read_strobe_ff && cur_slot == 10'd270; endsequence
    sequence h2_s; read_strobe_ff && cur_slot == 10'd271; endsequence
    sequence h3_s; read_strobe_ff && cur_slot == 10'd272; endsequence
    sequence fill_s; read_strobe_ff && cur_slot == 10'd273; endsequence

    stuff_excl_a: assert property (!(read_pos_stuff_ff && read_neg_stuff_ff))
        else $error("increment and decrement in one frame");
    adj_hold_a: assert property (!read_frame_start_ff |->
        $stable({read_pos_stuff_ff, read_neg_stuff_ff, pointer_value_ff})) else $error("frame state moved");
    ptr_keep_a: assert property (frame_s ##0 !$past(adj_now) |-> $stable(pointer_value_ff))
        else $error("pointer moved without adjustment");
    ptr_inc_a: assert property (frame_s ##0 $past(read_pos_stuff_ff) |-> pointer_value_ff ==
        ($past(pointer_value_ff) == `SBP_PTR_MAX ? 10'h000 : $past(pointer_value_ff) + 10'h001))
        else $error("pointer not incremented");
    ptr_dec_a: assert property (frame_s ##0 $past(read_neg_stuff_ff) |-> pointer_value_ff ==
        ($past(pointer_value_ff) == 10'h000 ? `SBP_PTR_MAX : $past(pointer_value_ff) - 10'h001))
        else $error("pointer not decremented");
    adj_space_a: assert property (frame_s ##0 $past(adj_now) |-> !adj_now)
        else $error("adjustment right after adjustment");
    h1_word_a: assert property (h1_s |->
        buffer_read_data_ff == {`SBP_NDF_NORMAL, `SBP_SS_BITS, exp_word[9:8]}) else $error("bad first pointer byte");
    h2_word_a: assert property (h2_s |-> buffer_read_data_ff == exp_word[7:0])
        else $error("bad second pointer byte");
    h3_slot_a: assert property (h3_s |-> read_payload_ff == read_neg_stuff_ff)
        else $error("H3 payload use wrong");
    stuff_slot_a: assert property (fill_s ##0 read_pos_stuff_ff |->
        !read_payload_ff && buffer_read_data_ff == `SBP_FILL_BYTE) else $error("dummy byte missing");
endmodule

// File: dv/sbp_upstream_model.sv
// Upstream element: free-running byte clock and counting payload bytes.
// Assumes the bench sets the half period in ns and gates sending.
`timescale 1ns/1ps
module sbp_upstream_model (
    // Bench control
    input wire       send_en,
    input wire [7:0] half_ns,
    // Upstream link
    output reg       upstream_write_clock,
    output reg       buffer_write_enable,
    output reg [7:0] buffer_write_data
);
    reg [7:0] seq_ff;

    // Data moves on the fall, far from the sampled rise; idle data is
    // inverted each period so a stale byte never looks valid
    initial begin
        upstream_write_clock = 1'b0;
        buffer_write_enable = 1'b0;
        buffer_write_data = 8'h00;
        seq_ff = 8'h01;
        forever begin
            #(half_ns) upstream_write_clock = 1'b1;
            #(half_ns) upstream_write_clock = 1'b0;
            buffer_write_enable = send_en;
            if (send_en) begin
                buffer_write_data = seq_ff;
                seq_ff = seq_ff + 8'h01;
            end else begin
                buffer_write_data = ~buffer_write_data;
            end
        end
    end
endmodule

// File: dv/sbp_slip_buffer_tb.sv
// Bench: start-up, starved increment and flooded decrement frames.
// Assumes checker and upstream model are compiled before this file.
`timescale 1ns/1ps
`include "sbp_defines.vh"
module sbp_slip_buffer_tb;
    reg        clk, sys_rst, local_read_clock, send_en;
    reg  [7:0] half_ns = 8'd62;
    wire       upstream_write_clock, buffer_write_enable;
    wire [7:0] buffer_write_data, buffer_read_data_ff;
    wire       write_ready_ff, write_overflow_ff, read_strobe_ff, read_frame_start_ff, read_payload_ff;
    wire       read_j1_ff, read_pos_stuff_ff, read_neg_stuff_ff, read_underrun_ff;
    wire [9:0] pointer_value_ff;
    integer    n_errors, check_count, frame_n;
    reg  [9:0] slot;
    reg  [7:0] h_byte [0:3];
    reg        h_pay [0:3];
    reg        h_j1, ovf_seen, full_seen, und_seen;

    sbp_upstream_model u_sbp_upstream_model (.send_en(send_en), .half_ns(half_ns),
        .upstream_write_clock(upstream_write_clock), .buffer_write_enable(buffer_write_enable),
        .buffer_write_data(buffer_write_data));
    sbp_slip_buffer u_sbp_slip_buffer (.clk(clk), .sys_rst(sys_rst),
        .upstream_write_clock(upstream_write_clock), .buffer_write_enable(buffer_write_enable),
        .buffer_write_data(buffer_write_data), .write_ready_ff(write_ready_ff),
        .write_overflow_ff(write_overflow_ff), .local_read_clock(local_read_clock),
        .buffer_read_data_ff(buffer_read_data_ff), .read_strobe_ff(read_strobe_ff),
        .read_frame_start_ff(read_frame_start_ff), .read_payload_ff(read_payload_ff),
        .read_j1_ff(read_j1_ff), .read_pos_stuff_ff(read_pos_stuff_ff), .read_neg_stuff_ff(read_neg_stuff_ff),
        .pointer_value_ff(pointer_value_ff), .read_underrun_ff(read_underrun_ff));

    // ****************
    // Clocks, monitor, helpers
    // ****************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Read clock is unrelated in phase to clk
    initial begin
        local_read_clock = 1'b0;
        forever #62.5 local_read_clock = ~local_read_clock;
    end

    // H1, H2, H3 and the byte after H3 (slots 270 to 273) of every frame; the receiver must know where stuffing sits
    always @(posedge clk) begin
        if (!sys_rst && read_strobe_ff) begin
            slot = read_frame_start_ff ? 10'h000 : slot + 10'h001;
            frame_n = frame_n + read_frame_start_ff;
            if (slot >= 10'd270 && slot <= 10'd273) begin
                h_byte[slot - 10'd270] = buffer_read_data_ff;
                h_pay[slot - 10'd270] = read_payload_ff;
            end
            if (slot == 10'd273) begin
                h_j1 = read_j1_ff;
            end
        end
        if (!sys_rst) begin
            ovf_seen = ovf_seen | write_overflow_ff;
            und_seen = und_seen | read_underrun_ff;
            full_seen = full_seen | (frame_n > 0 && !write_ready_ff);
        end
    end

    task check(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
            end
        end
    endtask

    function [15:0] hword(input [9:0] p, input [9:0] m);
        hword = {`SBP_NDF_NORMAL, `SBP_SS_BITS, p ^ m};
    endfunction

    // Bounded wait until slot s of frame f has gone out
    task wait_slot(input integer f, input integer s);
        integer k;
        begin
            k = 0;
            while (!(frame_n == f && slot > s) && k < 20000) begin
                @(posedge clk);
                k = k + 1;
            end
            check(k < 20000, 1'b1);
        end
    endtask

    // Row 3 of frame f has gone out up to slot 274
    task wait_row3(input integer f);
        begin
            wait_slot(f, 274);
        end
    endtask

    task end_of_test;
        begin
            $display("errors %0d checks %0d", n_errors, check_count);
            if (n_errors == 0 && check_count > 0) begin
                $display("== PASSED ==");
            end else begin
                $display("== FAILED ==");
            end
            $finish;
        end
    endtask

    // ****************
    // Scenarios
    // ****************
    task t_reset;
        begin
            check({write_ready_ff, read_pos_stuff_ff, read_neg_stuff_ff}, 3'b000);
            check(pointer_value_ff, `SBP_PTR_RESET);
        end
    endtask

    // A short burst starts the envelope: J1 right after H3 at pointer zero
    task t_start;
        begin
            send_en = 1'b1;
            repeat (8) @(posedge upstream_write_clock);
            send_en = 1'b0;
            wait_row3(0);
            check({h_pay[3], h_j1, und_seen, pointer_value_ff}, {3'b110, 10'h000});
            check(write_ready_ff, 1'b1);
        end
    endtask

    // Starved buffer: dummy after H3, I bits inverted, then pointer + 1;
    // a short burst just before H1 leaves bytes that the stuff slot must not take
    task t_increment;
        begin
            wait_slot(1, 267);
            send_en = 1'b1;
            repeat (4) @(posedge upstream_write_clock);
            send_en = 1'b0;
            wait_row3(1);
            check({read_pos_stuff_ff, read_neg_stuff_ff, und_seen}, 3'b101);
            check({h_byte[0], h_byte[1]}, hword(10'h000, `SBP_I_MASK));
            check({h_byte[2], h_pay[2], h_byte[3], h_pay[3]}, {`SBP_FILL_BYTE, 1'b0, `SBP_FILL_BYTE, 1'b0});
            wait_row3(2);
            check({read_pos_stuff_ff, pointer_value_ff}, {1'b0, 10'h001});
            check({h_byte[0], h_byte[1]}, hword(10'h001, 10'h000));
        end
    endtask

    // Flooded buffer: payload in H3, D bits inverted, then pointer - 1
    task t_decrement;
        begin
            half_ns = 8'd50;
            send_en = 1'b1;
            wait_row3(3);
            check({ovf_seen, full_seen}, 2'b11);
            check({read_neg_stuff_ff, read_pos_stuff_ff}, 2'b10);
            check({h_byte[0], h_byte[1]}, hword(10'h001, `SBP_D_MASK));
            check(h_pay[2], 1'b1);
            check(h_pay[3], 1'b1);
            wait_row3(4);
            check({read_neg_stuff_ff, pointer_value_ff}, {1'b0, 10'h000});
            check({h_byte[0], h_byte[1]}, hword(10'h000, 10'h000));
            send_en = 1'b0;
        end
    endtask

    // Five frames of about 101 us each fit well inside this span
    initial begin
        #600000;
        n_errors = n_errors + 1;
        end_of_test;
    end

    initial begin
        n_errors = 0;
        check_count = 0;
        frame_n = -1;
        slot = 10'h000;
        ovf_seen = 1'b0;
        full_seen = 1'b0;
        und_seen = 1'b0;
        send_en = 1'b0;
        sys_rst = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        t_reset;
        sys_rst = 1'b0;
        t_start;
        t_increment;
        t_decrement;
        end_of_test;
    end
endmodule

bind sbp_slip_buffer sbp_checker u_sbp_checker (.clk(clk), .sys_rst(sys_rst),
    .read_strobe_ff(read_strobe_ff), .read_frame_start_ff(read_frame_start_ff),
    .read_payload_ff(read_payload_ff), .read_pos_stuff_ff(read_pos_stuff_ff),
    .read_neg_stuff_ff(read_neg_stuff_ff), .pointer_value_ff(pointer_value_ff),
    .buffer_read_data_ff(buffer_read_data_ff));
